// File: hdl/rcwdt_pkg.sv
/*
  rcwdt_pkg: register map, field layout, key values and reset values of the watchdog unit.
  assumes: compiled before every other file of the block.
*/
package rcwdt_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [3:0]  OFS_CONTROL    = 4'h0;
  localparam logic [3:0]  OFS_KICK       = 4'h4;
  localparam logic [3:0]  OFS_SYS        = 4'h8;

  // ----------------------------------------------------------------
  // control fields
  // ----------------------------------------------------------------
  localparam int          CTL_EN_BIT     = 0;
  localparam int          CTL_PSEL_LO    = 8;
  localparam int          CTL_PSEL_HI    = 12;
  localparam int          CTL_KEY_LO     = 24;
  localparam int          CTL_KEY_HI     = 31;
  localparam logic [7:0]  KEY_FIRST      = 8'h55;
  localparam logic [7:0]  KEY_SECOND     = 8'hAA;
  localparam logic [31:0] CONTROL_RESET  = 32'h0000_0000;

  // ----------------------------------------------------------------
  // system status fields (offset 0x08, read only)
  // ----------------------------------------------------------------
  localparam int          SYS_KEY_ARMED  = 0;
  localparam int          SYS_FIRED      = 1;
  localparam int          SYS_RC_ON      = 2;
  localparam int          SYS_FROZEN     = 3;

  localparam int          PRESC_W        = 32;

endpackage : rcwdt_pkg

// File: hdl/rcwdt_prescaler.sv
/*
  rcwdt_prescaler: free counter advanced on each rc oscillator tick, flags when the selected period is reached.
  assumes: tick input is already a one-cycle pulse in the system clock domain.
*/
module rcwdt_prescaler #(
  parameter int W = 32
) (
  input  wire logic         clk_sys_in,
  input  wire logic         srst_in,
  input  wire logic         run_in,
  input  wire logic         tick_in,
  input  wire logic         restart_in,
  input  wire logic [4:0]   psel_in,
  output logic              expire_out,
  output logic [W-1:0]      count_out
);

  logic [W:0] cnt_r;
  logic [W:0] limit;

  // period is 2^(psel+1) ticks; one spare bit keeps psel=31 reachable
  // shift amount is widened first so that psel=31 does not wrap to a shift of zero
  assign limit     = {{W{1'b0}}, 1'b1} << ({1'b0, psel_in} + 6'h01);
  assign count_out = cnt_r[W-1:0];

  always_ff @(posedge clk_sys_in) begin
    if (srst_in || restart_in || !run_in) begin
      cnt_r      <= '0;
      expire_out <= 1'b0;
    end else if (tick_in) begin
      if (cnt_r + 1'b1 >= limit) begin
        cnt_r      <= '0;
        expire_out <= 1'b1;
      end else begin
        cnt_r      <= cnt_r + 1'b1;
        expire_out <= 1'b0;
      end
    end else begin
      expire_out <= 1'b0;
    end
  end

endmodule : rcwdt_prescaler

// File: hdl/rcwdt_top.sv
/*
  rcwdt_top: watchdog unit with avalon-mm slave, key-protected control, kick register and soft reset output.
  assumes: rc_osc_tick_in is a one-cycle pulse per rc oscillator period, already in the clk_sys_in domain;
  sleep and debug inputs are synchronous to clk_sys_in.
*/
// What this block does
// - prescaler is 32 bits and advances only on rc oscillator ticks.
// - enable bit starts watchdog and requests rc oscillator on; zero stops it.
// - time-out equals 2^(psel+1) rc oscillator cycles.
// - period select lives in control bits 12:8.
// - after a watchdog reset a new period starts and keeps counting.
// - control changes need writes with key 0x55 then 0xAA, other bits equal.
// - key byte always reads zero.
// - kick writes at offset 0x04 before time-out; else a soft reset.
// - enabled watchdog stays clocked in every sleep mode.
// - static sleep request becomes shutdown while enabled.
// - prescaler freezes in debug halt unless debugger keeps peripherals running.
// - kick accepts any value and reads zero.
module rcwdt_top #(
  parameter int PRESC_W = rcwdt_pkg::PRESC_W
) (
  input  wire logic        clk_sys_in,
  input  wire logic        srst_in,
  input  wire logic [3:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  input  wire logic [3:0]  avs_byteenable_in,
  output logic [31:0]      avs_readdata_out,
  output logic             avs_waitrequest_out,
  output logic [1:0]       avs_response_out,
  input  wire logic        rc_osc_tick_in,
  input  wire logic        sleep_static_req_in,
  input  wire logic        debug_halt_in,
  input  wire logic        dbg_keep_periph_in,
  output logic             soft_reset_out,
  output logic             rc_osc_clock_req_out,
  output logic             sleep_clock_keep_out,
  output logic             sleep_shutdown_out,
  output logic             sleep_static_out
);

  // ----------------------------------------------------------------
  // bus slave: one wait state, answer on the second edge of a request
  // ----------------------------------------------------------------
  logic        ack_r;
  logic        req;
  logic        wr_acc;
  logic        rd_acc;
  logic        ctl_en_r;
  logic [4:0]  ctl_psel_r;
  logic        key_armed_r;
  logic [23:0] key_body_r;
  logic        fired_r;
  logic        kick;
  logic        frozen;
  logic        run;
  logic        expire;

  assign req    = (avs_read_in || avs_write_in) && !ack_r;
  // a write commits at the edge where the master samples waitrequest low, not when it is taken
  assign wr_acc = avs_write_in && ack_r;
  assign rd_acc = avs_read_in && req;

  function automatic logic mapped(input logic [3:0] a);
    mapped = (a == rcwdt_pkg::OFS_CONTROL) || (a == rcwdt_pkg::OFS_KICK) || (a == rcwdt_pkg::OFS_SYS);
  endfunction : mapped

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      ack_r               <= 1'b0;
      avs_waitrequest_out <= 1'b1;
    end else begin
      ack_r               <= req;
      avs_waitrequest_out <= !req;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      avs_readdata_out <= 32'h0000_0000;
      avs_response_out <= 2'h0;
    end else if (req) begin
      avs_response_out <= mapped(avs_address_in) ? 2'h0 : 2'h2;
      avs_readdata_out <= 32'h0000_0000;
      if (rd_acc) begin
        case (avs_address_in)
          rcwdt_pkg::OFS_CONTROL: begin
            // key byte reads zero
            avs_readdata_out[rcwdt_pkg::CTL_EN_BIT]                        <= ctl_en_r;
            avs_readdata_out[rcwdt_pkg::CTL_PSEL_HI:rcwdt_pkg::CTL_PSEL_LO] <= ctl_psel_r;
          end
          rcwdt_pkg::OFS_SYS: begin
            avs_readdata_out[rcwdt_pkg::SYS_KEY_ARMED] <= key_armed_r;
            avs_readdata_out[rcwdt_pkg::SYS_FIRED]     <= fired_r;
            avs_readdata_out[rcwdt_pkg::SYS_RC_ON]     <= ctl_en_r;
            avs_readdata_out[rcwdt_pkg::SYS_FROZEN]    <= frozen;
          end
          default: begin
            avs_readdata_out <= 32'h0000_0000;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // key-protected control register
  // ----------------------------------------------------------------
  // only a full-word write counts: a partial lane write could split key and body
  logic ctl_wr;
  logic [7:0] wkey;
  assign ctl_wr = wr_acc && (avs_address_in == rcwdt_pkg::OFS_CONTROL) && (avs_byteenable_in == 4'hF);
  assign wkey   = avs_writedata_in[rcwdt_pkg::CTL_KEY_HI:rcwdt_pkg::CTL_KEY_LO];

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      key_armed_r <= 1'b0;
      key_body_r  <= 24'h00_0000;
    end else if (ctl_wr) begin
      // any control write other than the first key disarms the sequence
      key_armed_r <= (wkey == rcwdt_pkg::KEY_FIRST);
      key_body_r  <= avs_writedata_in[23:0];
    end else if (wr_acc) begin
      key_armed_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      ctl_en_r   <= rcwdt_pkg::CONTROL_RESET[rcwdt_pkg::CTL_EN_BIT];
      ctl_psel_r <= rcwdt_pkg::CONTROL_RESET[rcwdt_pkg::CTL_PSEL_HI:rcwdt_pkg::CTL_PSEL_LO];
    end else if (ctl_wr && key_armed_r && wkey == rcwdt_pkg::KEY_SECOND
                 && avs_writedata_in[23:0] == key_body_r) begin
      ctl_en_r   <= avs_writedata_in[rcwdt_pkg::CTL_EN_BIT];
      ctl_psel_r <= avs_writedata_in[rcwdt_pkg::CTL_PSEL_HI:rcwdt_pkg::CTL_PSEL_LO];
    end
  end

  // ----------------------------------------------------------------
  // counting, kick and reset
  // ----------------------------------------------------------------
  assign kick   = wr_acc && (avs_address_in == rcwdt_pkg::OFS_KICK);
  assign frozen = debug_halt_in && !dbg_keep_periph_in;
  assign run    = ctl_en_r;

  rcwdt_prescaler #(
    .W (PRESC_W)
  ) u_presc (
    .clk_sys_in (clk_sys_in),
    .srst_in    (srst_in),
    .run_in     (run),
    .tick_in    (rc_osc_tick_in && !frozen),
    .restart_in (kick),
    .psel_in    (ctl_psel_r),
    .expire_out (expire),
    .count_out  ()
  );

  // the watchdog is not reset by its own soft reset, so counting goes on through it
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      soft_reset_out <= 1'b0;
      fired_r        <= 1'b0;
    end else begin
      soft_reset_out <= expire;
      if (expire) begin
        fired_r <= 1'b1;
      end else if (kick) begin
        fired_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // sleep controller hints
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      rc_osc_clock_req_out <= 1'b0;
      sleep_clock_keep_out <= 1'b0;
      sleep_shutdown_out   <= 1'b0;
      sleep_static_out     <= 1'b0;
    end else begin
      rc_osc_clock_req_out <= ctl_en_r;
      sleep_clock_keep_out <= ctl_en_r;
      sleep_shutdown_out   <= sleep_static_req_in && ctl_en_r;
      sleep_static_out     <= sleep_static_req_in && !ctl_en_r;
    end
  end

endmodule : rcwdt_top

// File: tb/rcwdt_top_assertions.sv
/*
  rcwdt_top_assertions: timing checks on the watchdog unit ports.
  assumes: bound to rcwdt_top; one clock, srst_in synchronous.
*/
module rcwdt_top_assertions (
  input wire logic        clk_sys_in,
  input wire logic        srst_in,
  input wire logic [3:0]  avs_address_in,
  input wire logic        avs_read_in,
  input wire logic        avs_write_in,
  input wire logic [31:0] avs_readdata_out,
  input wire logic        avs_waitrequest_out,
  input wire logic        soft_reset_out,
  input wire logic        rc_osc_clock_req_out,
  input wire logic        sleep_clock_keep_out,
  input wire logic        sleep_static_req_in,
  input wire logic        sleep_shutdown_out,
  input wire logic        sleep_static_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (srst_in);
  logic rd_done;
  assign rd_done = avs_read_in && !avs_waitrequest_out;
  a_one_wait: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out)
    else $error("no answer after one wait state");
  a_wait_short: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
    else $error("answer longer than one cycle");
  a_key_reads_zero: assert property (rd_done && avs_address_in == 4'h0 |-> avs_readdata_out[31:24] == 8'h00)
    else $error("key byte read nonzero");
  a_kick_reads_zero: assert property (rd_done && avs_address_in == 4'h4 |-> avs_readdata_out == 32'h0)
    else $error("kick read nonzero");
  a_clock_kept: assert property (rc_osc_clock_req_out == sleep_clock_keep_out)
    else $error("sleep clock keep differs from enable");
  a_shutdown_map: assert property (!srst_in |=>
    sleep_shutdown_out == ($past(sleep_static_req_in) && rc_osc_clock_req_out)) else $error("shutdown wrong");
  a_static_map: assert property (!srst_in |=>
    sleep_static_out == ($past(sleep_static_req_in) && !rc_osc_clock_req_out)) else $error("static wrong");
  a_reset_pulse: assert property (soft_reset_out |=> !soft_reset_out)
    else $error("soft reset longer than one cycle");
  a_off_no_fire: assert property (!rc_osc_clock_req_out [*3] |-> !soft_reset_out)
    else $error("soft reset while disabled");
  cover property (soft_reset_out);
  cover property (sleep_shutdown_out);
  cover property (sleep_static_out);
endmodule : rcwdt_top_assertions

bind rcwdt_top rcwdt_top_assertions chk_u (.clk_sys_in, .srst_in, .avs_address_in, .avs_read_in, .avs_write_in,
  .avs_readdata_out, .avs_waitrequest_out, .soft_reset_out, .rc_osc_clock_req_out, .sleep_clock_keep_out,
  .sleep_static_req_in, .sleep_shutdown_out, .sleep_static_out);

// File: tb/rcwdt_top_test.sv
/*
  rcwdt_top_test: directed bench for the watchdog unit through its avalon-mm slave.
  assumes: rcwdt_pkg and rcwdt_top compiled first; rc ticks are made here as one-cycle pulses.
*/
module rcwdt_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys_in = 1'b0, srst_in = 1'b1, avs_read_in = 1'b0, avs_write_in = 1'b0;
  logic        rc_osc_tick_in = 1'b0, sleep_static_req_in = 1'b0, debug_halt_in = 1'b0, dbg_keep_periph_in = 1'b0;
  logic [3:0]  avs_address_in = 4'h0, avs_byteenable_in = 4'hF;
  logic [31:0] avs_writedata_in = 32'h0, avs_readdata_out, rdata;
  logic [1:0]  avs_response_out, resp;
  logic        avs_waitrequest_out, soft_reset_out, rc_osc_clock_req_out, sleep_clock_keep_out;
  logic        sleep_shutdown_out, sleep_static_out, seen;
  int          num_errors = 0, checks_done = 0;

  rcwdt_top dut_u (.clk_sys_in, .srst_in, .avs_address_in, .avs_read_in, .avs_write_in, .avs_writedata_in,
    .avs_byteenable_in, .avs_readdata_out, .avs_waitrequest_out, .avs_response_out, .rc_osc_tick_in,
    .sleep_static_req_in, .debug_halt_in, .dbg_keep_periph_in, .soft_reset_out, .rc_osc_clock_req_out,
    .sleep_clock_keep_out, .sleep_shutdown_out, .sleep_static_out);

  initial begin
    forever #4 clk_sys_in = ~clk_sys_in;
  end

  task automatic finish_test();
    if (num_errors == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : finish_test

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // one transfer, held until waitrequest is sampled low
  task automatic bus(input logic rd, input logic [3:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_sys_in);
    avs_read_in <= rd;
    avs_write_in <= !rd;
    avs_address_in <= a;
    avs_writedata_in <= d;
    for (n = 0; n < 20; n++) begin
      @(posedge clk_sys_in);
      if (avs_waitrequest_out === 1'b0) break;
    end
    if (n == 20) begin
      num_errors++;
      finish_test();
    end
    rdata = avs_readdata_out;
    resp = avs_response_out;
    avs_read_in <= 1'b0;
    avs_write_in <= 1'b0;
  endtask : bus

  task automatic ctl(input logic [23:0] v);
    bus(1'b0, 4'h0, {8'h55, v});
    bus(1'b0, 4'h0, {8'hAA, v});
  endtask : ctl

  // cnt ticks; a soft reset anywhere in them must match exp
  task automatic tick(input int cnt, input logic exp);
    seen = 1'b0;
    repeat (cnt) begin
      @(posedge clk_sys_in);
      rc_osc_tick_in <= 1'b1;
      @(posedge clk_sys_in);
      rc_osc_tick_in <= 1'b0;
      repeat (4) @(posedge clk_sys_in) seen |= soft_reset_out;
    end
    chk("soft reset", {31'h0, exp}, {31'h0, seen});
  endtask : tick

  initial begin
    repeat (16) @(posedge clk_sys_in);
    srst_in <= 1'b0;
    bus(1'b1, 4'h0, 32'h0);
    chk("control", 32'h0, rdata);
    bus(1'b1, 4'h4, 32'h0);
    chk("kick read", 32'h0, rdata);
    chk("response", 32'h0, {30'h0, resp});
    // second key alone, changed bits, and a kick in between must all be ignored
    bus(1'b0, 4'h0, 32'hAA00_0101);
    bus(1'b0, 4'h0, 32'h5500_0101);
    bus(1'b0, 4'h0, 32'hAA00_0001);
    bus(1'b0, 4'h0, 32'h5500_0101);
    bus(1'b0, 4'h4, 32'h0);
    bus(1'b0, 4'h0, 32'hAA00_0101);
    bus(1'b1, 4'h0, 32'h0);
    chk("control", 32'h0, rdata);
    ctl(24'h00_0101);
    bus(1'b1, 4'h0, 32'h0);
    chk("control", 32'h0000_0101, rdata);
    chk("rc clock", 32'h1, {31'h0, rc_osc_clock_req_out});
    repeat (2) begin
      tick(3, 1'b0);
      tick(1, 1'b1);
    end
    tick(3, 1'b0);
    bus(1'b0, 4'h4, 32'hFFFF_FFFF);
    tick(3, 1'b0);
    tick(1, 1'b1);
    debug_halt_in <= 1'b1;
    bus(1'b1, 4'h8, 32'h0);
    chk("status", 32'h0000_000E, rdata);
    tick(6, 1'b0);
    dbg_keep_periph_in <= 1'b1;
    tick(4, 1'b1);
    debug_halt_in <= 1'b0;
    sleep_static_req_in <= 1'b1;
    repeat (3) @(posedge clk_sys_in);
    chk("shutdown", 32'h1, {31'h0, sleep_shutdown_out});
    chk("clock kept", 32'h1, {31'h0, sleep_clock_keep_out});
    chk("static", 32'h0, {31'h0, sleep_static_out});
    ctl(24'h00_0100);
    repeat (3) @(posedge clk_sys_in);
    chk("static", 32'h1, {31'h0, sleep_static_out});
    chk("rc clock", 32'h0, {31'h0, rc_osc_clock_req_out});
    chk("shutdown", 32'h0, {31'h0, sleep_shutdown_out});
    chk("clock kept", 32'h0, {31'h0, sleep_clock_keep_out});
    tick(8, 1'b0);
    // a key sequence on a partial lane write must not reach the control register
    sleep_static_req_in <= 1'b0;
    avs_byteenable_in <= 4'h1;
    ctl(24'h00_0001);
    avs_byteenable_in <= 4'hF;
    bus(1'b1, 4'h0, 32'h0);
    chk("control", 32'h0000_0100, rdata);
    // reset while the watchdog is disabled with psel=1 returns control to its reset value
    srst_in <= 1'b1;
    repeat (2) @(posedge clk_sys_in);
    srst_in <= 1'b0;
    bus(1'b1, 4'h0, 32'h0);
    chk("control after reset", 32'h0, rdata);
    ctl(24'h00_0001);
    tick(1, 1'b0);
    tick(1, 1'b1);
    bus(1'b1, 4'hC, 32'h0);
    chk("unmapped response", 32'h2, {30'h0, resp});
    finish_test();
  end
endmodule : rcwdt_top_test
